/* File: image_port_pkg.sv */
package image_port_pkg;

	// Stream and FIFO geometry
	localparam int DATA_W = 32;
	localparam int FIFO_DEPTH = 32;
	localparam int PTR_W = 5;
	localparam int CNT_W = 6;
	localparam logic [CNT_W-1:0] FIFO_FULL_CNT = 6'h20;

	// Register indices and byte addresses (index times four)
	localparam logic [7:0] IDX_GATING = 8'h84;
	localparam logic [7:0] IDX_ARB = 8'h86;
	localparam logic [7:0] IDX_STATUS = 8'h90;
	localparam logic [7:0] IDX_MASK = 8'h91;
	localparam logic [7:0] IDX_FILL = 8'h92;
	localparam logic [9:0] ADDR_GATING = {IDX_GATING, 2'h0};
	localparam logic [9:0] ADDR_ARB = {IDX_ARB, 2'h0};
	localparam logic [9:0] ADDR_STATUS = {IDX_STATUS, 2'h0};
	localparam logic [9:0] ADDR_MASK = {IDX_MASK, 2'h0};
	localparam logic [9:0] ADDR_FILL = {IDX_FILL, 2'h0};

	// Arbitration register fields
	localparam int ARB_MODE_LO = 6;
	localparam int FLAG0_EXT_POS = 5;
	localparam int FLAG1_EXT_POS = 4;
	localparam int FULL_SEL_LO = 2;
	localparam int EMPTY_SEL_LO = 0;
	localparam logic [7:0] ARB_RST = 8'h00;

	// Gating register fields
	localparam int FLAG0_SEL_LO = 0;
	localparam int FLAG1_SEL_LO = 2;
	localparam logic [3:0] GATING_RST = 4'h0;

	// Status and mask bits
	localparam int ST_W = 3;
	localparam int ST_FULL = 0;
	localparam int ST_EMPTY = 1;
	localparam int ST_UNDER = 2;
	localparam logic [ST_W-1:0] MASK_RST = 3'h0;

	// Flag thresholds in Dwords
	localparam logic [CNT_W-1:0] AE_LVL0 = 6'h10;
	localparam logic [CNT_W-1:0] AE_LVL1 = 6'h08;
	localparam logic [CNT_W-1:0] AE_LVL2 = 6'h04;
	localparam logic [CNT_W-1:0] AF_LVL0 = 6'h10;
	localparam logic [CNT_W-1:0] AF_LVL1 = 6'h18;
	localparam logic [CNT_W-1:0] AF_LVL2 = 6'h1c;
	localparam logic [CNT_W-1:0] AF_LVL3 = 6'h20;

	// Bus transfer type bit that marks an active transfer
	localparam int HTRANS_ACTIVE = 1;

	// Output port modes
	typedef enum logic [1:0] {
		MODE_OFF,
		MODE_VIDEO,
		MODE_TEXT,
		MODE_BOTH
	} arb_mode_t;

	// Arbiter grant states
	typedef enum logic [1:0] {
		GRANT_NONE,
		GRANT_TEXT,
		GRANT_VIDEO
	} grant_t;

endpackage

/* File: port_fifo_mem.sv */
`timescale 1ns/10ps
module port_fifo_mem #(
	parameter int DATA_W = 32,
	parameter int DEPTH = 32,
	parameter int ADDR_W = $clog2(DEPTH)
)
(
	// Clock, reset, enable
	input wire logic mclk,
	input wire logic resetn,
	input wire logic ce,
	// Write side
	input wire logic wr_en,
	input wire logic [ADDR_W-1:0] wr_addr,
	input wire logic [DATA_W-1:0] wr_data,
	// Read side
	input wire logic rd_en,
	input wire logic [ADDR_W-1:0] rd_addr,
	output logic [DATA_W-1:0] rd_data
);

	// Storage, no reset needed
	logic [DATA_W-1:0] mem [DEPTH];

	// Write port
	always_ff @(posedge mclk)
	begin
		if (ce && wr_en)
			mem[wr_addr] <= wr_data;
	end

	// Registered read port
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			rd_data <= '0;
		else if (ce && rd_en)
			rd_data <= mem[rd_addr];
	end

endmodule

/* File: flag_level_compare.sv */
`timescale 1ns/10ps
module flag_level_compare
	import image_port_pkg::*;
(
	// Clock, reset, enable
	input wire logic mclk,
	input wire logic resetn,
	input wire logic ce,
	// Fill level and threshold codes
	input wire logic [CNT_W-1:0] fill_count,
	input wire logic [1:0] empty_sel,
	input wire logic [1:0] full_sel,
	// Flags
	output logic almost_empty,
	output logic almost_full
);

	// Almost-empty compare, re-evaluated every clock
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			almost_empty <= 1'b1;
		else if (ce)
		begin
			case (empty_sel)
				2'h0: almost_empty <= fill_count < AE_LVL0; // see RULE5
				2'h1: almost_empty <= fill_count < AE_LVL1; // see RULE5
				2'h2: almost_empty <= fill_count < AE_LVL2; // see RULE5
				default: almost_empty <= fill_count == '0; // see RULE10
			endcase
		end
	end

	// Almost-full compare, re-evaluated every clock
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			almost_full <= 1'b0;
		else if (ce)
		begin
			case (full_sel)
				2'h0: almost_full <= fill_count >= AF_LVL0; // see RULE6
				2'h1: almost_full <= fill_count >= AF_LVL1; // see RULE6
				2'h2: almost_full <= fill_count >= AF_LVL2; // see RULE6
				default: almost_full <= fill_count == AF_LVL3; // see RULE10
			endcase
		end
	end

	property p_empty_zero;
		@(posedge mclk) disable iff (!resetn)
		ce && empty_sel == 2'h3 && fill_count == 6'h01 |=> !almost_empty;
	endproperty
	a_empty_zero: assert property (p_empty_zero) // see RULE5
		else $error("almost empty set at one Dword with zero code");

	property p_full_top;
		@(posedge mclk) disable iff (!resetn)
		ce && full_sel == 2'h3 && fill_count == 6'h1f |=> !almost_full;
	endproperty
	a_full_top: assert property (p_full_top) // see RULE6
		else $error("almost full set below 32 Dwords with top code");

endmodule

/* File: image_port_fifo_arbiter.sv */
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/10ps
//Behaviour
//RULE1 - Mode 00 sends no words on port
//RULE2 - Mode 01 passes video only, never text
//RULE3 - Mode 10 passes text only, no timing codes
//RULE4 - Mode 11 passes both, text wins ties
//RULE5 - Almost-empty below 16, 8, 4, or zero
//RULE6 - Almost-full at 16, 24, 28, or 32
//RULE7 - Upper bit extends flag one gating select
//RULE8 - Upper bit extends flag zero gating select
//RULE9 - Mode and extensions high, thresholds low nibble
//RULE10 - Flags follow fill count each clock
module image_port_fifo_arbiter
	import image_port_pkg::*;
(
	// Clock, reset, enable
	input wire logic mclk,
	input wire logic resetn,
	input wire logic ce,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Video word source
	input wire logic [DATA_W-1:0] video_data,
	input wire logic video_valid,
	output logic video_ready,
	// Text word source
	input wire logic [DATA_W-1:0] text_data,
	input wire logic text_valid,
	output logic text_ready,
	// Image port towards host logic
	input wire logic port_read,
	output logic [DATA_W-1:0] port_data,
	output logic port_valid,
	output logic fifo_almost_empty_flag,
	output logic fifo_almost_full_flag,
	output logic [1:0] flag_out,
	// Interrupt
	output logic irq
);

	// Software registers
	logic [7:0] arb_reg;
	logic [3:0] gating_reg;
	logic [ST_W-1:0] status_reg;
	logic [ST_W-1:0] status_next;
	logic [ST_W-1:0] mask_reg;

	// Bus data phase state
	logic wr_pend_reg;
	logic [9:0] addr_reg;
	logic addr_ok;
	logic rd_take;
	logic [31:0] rd_mux;

	// FIFO bookkeeping
	logic [PTR_W-1:0] wr_ptr_reg;
	logic [PTR_W-1:0] rd_ptr_reg;
	logic [CNT_W-1:0] count_reg;
	logic [CNT_W-1:0] count_next;
	logic wr_en;
	logic rd_en;
	logic [DATA_W-1:0] wr_word;

	// Arbiter state
	grant_t grant_reg;
	grant_t grant_next;
	arb_mode_t mode;

	// Event edge memory
	logic af_d_reg;
	logic ae_d_reg;
	logic [ST_W-1:0] events;

	// Field views of the arbitration register
	assign mode = arb_mode_t'(arb_reg[ARB_MODE_LO +: 2]); // see RULE9

	// Address phase qualifier
	assign addr_ok = hsel && htrans[HTRANS_ACTIVE] && hready;
	assign rd_take = ce && addr_ok && !hwrite;

	// Read data selection; unmapped words read zero
	always_comb
	begin
		rd_mux = '0;
		case (haddr[9:0])
			ADDR_ARB: rd_mux[7:0] = arb_reg; // see RULE9
			ADDR_GATING: rd_mux[3:0] = gating_reg;
			ADDR_STATUS: rd_mux[ST_W-1:0] = status_reg;
			ADDR_MASK: rd_mux[ST_W-1:0] = mask_reg;
			ADDR_FILL: rd_mux[CNT_W-1:0] = count_reg;
			default: rd_mux = '0;
		endcase
	end

	// Capture the address phase for the following data phase
	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			wr_pend_reg <= 1'b0;
			addr_reg <= '0;
		end
		else if (ce)
		begin
			wr_pend_reg <= addr_ok && hwrite;
			if (addr_ok)
				addr_reg <= haddr[9:0];
		end
	end

	// Read data and response, zero wait states
	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			hrdata <= '0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else if (ce)
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (rd_take)
				hrdata <= rd_mux;
		end
	end

	// Arbitration and threshold register
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			arb_reg <= ARB_RST;
		else if (ce && wr_pend_reg && addr_reg == ADDR_ARB)
			arb_reg <= hwdata[7:0]; // see RULE9
	end

	// Gating select register, low two bits of each select
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			gating_reg <= GATING_RST;
		else if (ce && wr_pend_reg && addr_reg == ADDR_GATING)
			gating_reg <= hwdata[3:0];
	end

	// Interrupt mask register
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			mask_reg <= MASK_RST;
		else if (ce && wr_pend_reg && addr_reg == ADDR_MASK)
			mask_reg <= hwdata[ST_W-1:0];
	end

	// Sticky events: flag rises and a read of an empty FIFO
	assign events[ST_FULL] = fifo_almost_full_flag && !af_d_reg;
	assign events[ST_EMPTY] = fifo_almost_empty_flag && !ae_d_reg;
	assign events[ST_UNDER] = port_read && count_reg == '0;

	// Read of status clears it, but a new event wins
	always_comb
	begin
		status_next = status_reg;
		if (rd_take && haddr[9:0] == ADDR_STATUS)
			status_next = '0;
		status_next = status_next | events;
	end

	// Status, edge memory and interrupt line
	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			status_reg <= '0;
			af_d_reg <= 1'b0;
			ae_d_reg <= 1'b1;
			irq <= 1'b0;
		end
		else if (ce)
		begin
			status_reg <= status_next;
			af_d_reg <= fifo_almost_full_flag;
			ae_d_reg <= fifo_almost_empty_flag;
			irq <= |(status_next & mask_reg);
		end
	end

	// Word taken from the granted source
	assign wr_en = (grant_reg == GRANT_TEXT && text_valid) ||
		(grant_reg == GRANT_VIDEO && video_valid);
	assign wr_word = grant_reg == GRANT_TEXT ? text_data : video_data;

	// Port reads only while output is enabled
	assign rd_en = port_read && count_reg != '0 && mode != MODE_OFF;

	// Fill level after this cycle
	assign count_next = count_reg + CNT_W'(wr_en) - CNT_W'(rd_en);

	// Next grant: text first, one source per cycle, room checked
	always_comb
	begin
		grant_next = GRANT_NONE;
		if (count_next < FIFO_FULL_CNT)
		begin
			case (mode)
				MODE_OFF: grant_next = GRANT_NONE; // see RULE1
				MODE_VIDEO: // see RULE2
					if (video_valid)
						grant_next = GRANT_VIDEO;
				MODE_TEXT: // see RULE3
					if (text_valid)
						grant_next = GRANT_TEXT;
				MODE_BOTH: // see RULE4
					if (text_valid)
						grant_next = GRANT_TEXT;
					else if (video_valid)
						grant_next = GRANT_VIDEO;
				default: grant_next = GRANT_NONE;
			endcase
		end
	end

	// Grant state and the ready lines it drives
	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			grant_reg <= GRANT_NONE;
			text_ready <= 1'b0;
			video_ready <= 1'b0;
		end
		else if (ce)
		begin
			grant_reg <= grant_next;
			text_ready <= grant_next == GRANT_TEXT;
			video_ready <= grant_next == GRANT_VIDEO;
		end
	end

	// Pointers and fill level
	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end
		else if (ce)
		begin
			if (wr_en)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (rd_en)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			count_reg <= count_next; // see RULE10
		end
	end

	// Port valid follows the read enable by one cycle, alongside the registered read data
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			port_valid <= 1'b0;
		else if (ce)
			port_valid <= rd_en; // see RULE1
	end

	// Port FIFO storage
	port_fifo_mem #(
		.DATA_W(DATA_W),
		.DEPTH(FIFO_DEPTH),
		.ADDR_W(PTR_W)
	) u_mem (
		.mclk(mclk),
		.resetn(resetn),
		.ce(ce),
		.wr_en(wr_en),
		.wr_addr(wr_ptr_reg),
		.wr_data(wr_word),
		.rd_en(rd_en),
		.rd_addr(rd_ptr_reg),
		.rd_data(port_data)
	);

	// Level flags from the fill count
	flag_level_compare u_flags (
		.mclk(mclk),
		.resetn(resetn),
		.ce(ce),
		.fill_count(count_reg),
		.empty_sel(arb_reg[EMPTY_SEL_LO +: 2]),
		.full_sel(arb_reg[FULL_SEL_LO +: 2]),
		.almost_empty(fifo_almost_empty_flag),
		.almost_full(fifo_almost_full_flag)
	);

	// Gated flag outputs, three-bit source select each
	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : gen_flag
			logic [2:0] sel;
			logic [7:0] src;
			assign sel[1:0] = g == 0 ?
				gating_reg[FLAG0_SEL_LO +: 2] :
				gating_reg[FLAG1_SEL_LO +: 2];
			// Extension bit from the arbitration register
			assign sel[2] = g == 0 ? arb_reg[FLAG0_EXT_POS] : // see RULE8
				arb_reg[FLAG1_EXT_POS]; // see RULE7
			assign src = {1'b1, 1'b0, grant_reg == GRANT_VIDEO,
				grant_reg == GRANT_TEXT, !fifo_almost_full_flag,
				!fifo_almost_empty_flag, fifo_almost_full_flag,
				fifo_almost_empty_flag};
			always_ff @(posedge mclk)
			begin
				if (!resetn)
					flag_out[g] <= 1'b0;
				else if (ce)
					flag_out[g] <= src[sel];
			end
		end
	endgenerate

	// Two enabled cycles in one mode
	sequence s_mode2(arb_mode_t m);
		(ce && mode == m)[*2];
	endsequence

	property p_off_quiet;
		@(posedge mclk) disable iff (!resetn)
		s_mode2(MODE_OFF) |=> !port_valid && !text_ready && !video_ready;
	endproperty
	a_off_quiet: assert property (p_off_quiet) // see RULE1
		else $error("port active while output inhibited");

	property p_video_only;
		@(posedge mclk) disable iff (!resetn)
		s_mode2(MODE_VIDEO) |-> !text_ready;
	endproperty
	a_video_only: assert property (p_video_only) // see RULE2
		else $error("text granted in video-only mode");

	property p_text_only;
		@(posedge mclk) disable iff (!resetn)
		s_mode2(MODE_TEXT) |-> !video_ready;
	endproperty
	a_text_only: assert property (p_text_only) // see RULE3
		else $error("video granted in text-only mode");

	property p_text_first;
		@(posedge mclk) disable iff (!resetn)
		ce && mode == MODE_BOTH && text_valid && video_valid &&
			count_next < FIFO_FULL_CNT |=> text_ready && !video_ready;
	endproperty
	a_text_first: assert property (p_text_first) // see RULE4
		else $error("text lost priority over video");

	property p_flag1_ext;
		@(posedge mclk) disable iff (!resetn)
		(ce && arb_reg[FLAG1_EXT_POS] &&
			gating_reg[FLAG1_SEL_LO +: 2] == 2'h3)[*2] |-> flag_out[1];
	endproperty
	a_flag1_ext: assert property (p_flag1_ext) // see RULE7
		else $error("flag one extension bit ignored");

	property p_flag0_ext;
		@(posedge mclk) disable iff (!resetn)
		(ce && arb_reg[FLAG0_EXT_POS] &&
			gating_reg[FLAG0_SEL_LO +: 2] == 2'h2)[*2] |-> !flag_out[0];
	endproperty
	a_flag0_ext: assert property (p_flag0_ext) // see RULE8
		else $error("flag zero extension bit ignored");

	property p_arb_write;
		@(posedge mclk) disable iff (!resetn)
		ce && wr_pend_reg && addr_reg == ADDR_ARB |=>
			arb_reg == $past(hwdata[7:0]);
	endproperty
	a_arb_write: assert property (p_arb_write) // see RULE9
		else $error("arbitration register write lost");

	property p_count_up;
		@(posedge mclk) disable iff (!resetn)
		ce && wr_en && !rd_en |=> count_reg == $past(count_reg) + 6'h01;
	endproperty
	a_count_up: assert property (p_count_up) // see RULE10
		else $error("fill count missed a write");

endmodule

/* File: host_port_model.sv */
`timescale 1ns/10ps
// Host capture side: bursts reads from the image port and counts words
module host_port_model
(
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// Burst control from the bench
	input wire logic read_en,
	// Image port
	input wire logic port_valid,
	output logic port_read,
	output int n_words
);
	// Read request, one word per cycle while a burst is enabled
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			port_read <= 1'b0;
		else
			port_read <= read_en;
	end
	// Count words handed over by the port
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			n_words <= 0;
		else if (port_valid)
			n_words <= n_words + 1;
	end
endmodule

/* File: image_port_fifo_arbiter_tb.sv */
`timescale 1ns/10ps
module image_port_fifo_arbiter_tb
	import image_port_pkg::*;
;
	// Fixed words of each source, so every port word shows its origin
	localparam logic [31:0] TEXT_W = 32'h00aa_00aa;
	localparam logic [31:0] VIDEO_W = 32'h0055_0055;
	// Bench driven inputs
	logic mclk, resetn, hsel, hwrite, text_valid, video_valid, read_en;
	logic [31:0] haddr, hwdata, q, exp_word;
	logic [1:0] htrans;
	// Design outputs
	logic hreadyout, hresp, video_ready, text_ready, port_read, port_valid;
	logic fifo_almost_empty_flag, fifo_almost_full_flag, irq;
	logic [31:0] hrdata;
	logic [DATA_W-1:0] port_data;
	logic [1:0] flag_out;
	// Counters
	int mismatches = 0, n_checks = 0, n_words, base;
	int lv[13] = '{0, 3, 4, 7, 8, 15, 16, 23, 24, 27, 28, 31, 32};
	image_port_fifo_arbiter i_image_port_fifo_arbiter (.mclk, .resetn,
		.ce(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata,
		.video_data(VIDEO_W), .video_valid, .video_ready,
		.text_data(TEXT_W), .text_valid, .text_ready, .port_read, .port_data,
		.port_valid, .fifo_almost_empty_flag, .fifo_almost_full_flag,
		.flag_out, .irq);
	host_port_model i_host_port_model (.mclk, .resetn, .read_en,
		.port_valid, .port_read, .n_words);
	// Clock
	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	// Every delivered word must come from the expected source
	always @(posedge mclk)
		if (port_valid === 1'b1) chk("port_data", exp_word, port_data);
	// Compare and report
	task automatic chk(input string name, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", name, e, g);
		end
	endtask
	// One single AHB-Lite transfer, read data left in q
	task automatic bus(input logic [9:0] a, input logic w, input logic [31:0] d);
		@(posedge mclk);
		hsel <= 1'b1;
		haddr <= {22'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge mclk);
		while (hreadyout !== 1'b1) @(posedge mclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge mclk);
		while (hreadyout !== 1'b1) @(posedge mclk);
		q = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask
	task automatic rd(input logic [9:0] a, input logic [31:0] e);
		bus(a, 1'b0, 32'h0);
		chk("register", e, q);
	endtask
	// Hand n text words to the design, valid dropped at the last taking edge
	task automatic fill_n(input int n);
		int k;
		k = 0;
		if (n > 0)
		begin
			text_valid <= 1'b1;
			while (k < n)
			begin
				@(posedge mclk);
				if (text_valid && text_ready)
					k++;
			end
			text_valid <= 1'b0;
		end
	endtask
	// Host burst of fixed length
	task automatic drain(input int n);
		read_en <= 1'b1;
		repeat (n) @(posedge mclk);
		read_en <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask
	// Expected almost-empty for a threshold code and fill level
	function automatic logic ae_exp(input int c, input int n);
		case (c)
			0: return n < AE_LVL0;
			1: return n < AE_LVL1;
			2: return n < AE_LVL2;
			default: return n == 0;
		endcase
	endfunction
	// Expected almost-full for a threshold code and fill level
	function automatic logic af_exp(input int c, input int n);
		case (c)
			0: return n >= AF_LVL0;
			1: return n >= AF_LVL1;
			2: return n >= AF_LVL2;
			default: return n >= AF_LVL3;
		endcase
	endfunction
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Hang guard
	initial
	begin
		#(50 * 40000);
		mismatches++;
		finish_test;
	end
	// Main sequence
	initial
	begin
		resetn = 1'b0;
		{hsel, hwrite, text_valid, video_valid, read_en} = 5'h00;
		{haddr, hwdata, exp_word} = {32'h0, 32'h0, TEXT_W};
		htrans = 2'h0;
		repeat (16) @(posedge mclk);
		resetn <= 1'b1;
		// Reset values, readback, unmapped and read-only places
		rd(ADDR_ARB, {24'h0, ARB_RST});
		rd(ADDR_GATING, {28'h0, GATING_RST});
		rd(ADDR_MASK, {29'h0, MASK_RST});
		rd(10'h3fc, 32'h0);
		bus(ADDR_ARB, 1'b1, 32'h5a);
		rd(ADDR_ARB, 32'h5a);
		bus(ADDR_FILL, 1'b1, 32'h5);
		rd(ADDR_FILL, 32'h0);
		// Extension bits on each flag, with low selects 00 and then 10/11
		for (int e = 0; e < 8; e++)
		begin
			bus(ADDR_GATING, 1'b1, e[2] ? 32'he : 32'h0);
			bus(ADDR_ARB, 1'b1, {26'h0, e[1:0], 4'h0});
			repeat (3) @(posedge mclk);
			chk("flag_out", {30'h0, e[2] | ~e[0], ~e[2] & ~e[1]},
				{30'h0, flag_out});
		end
		// Every threshold code at levels around each boundary
		for (int i = 0; i < 13; i++)
		begin
			bus(ADDR_ARB, 1'b1, 32'h8f);
			fill_n(i == 0 ? 0 : lv[i] - lv[i - 1]);
			rd(ADDR_FILL, lv[i]);
			for (int c = 0; c < 4; c++)
			begin
				bus(ADDR_ARB, 1'b1, {24'h0, 4'h8, c[1:0], c[1:0]});
				repeat (3) @(posedge mclk);
				chk("almost_empty", ae_exp(c, lv[i]), fifo_almost_empty_flag);
				chk("almost_full", af_exp(c, lv[i]), fifo_almost_full_flag);
			end
		end
		drain(40);
		// Each mode with both sources pending
		for (int m = 0; m < 4; m++)
		begin
			exp_word = (m == 1) ? VIDEO_W : TEXT_W;
			bus(ADDR_ARB, 1'b1, {24'h0, m[1:0], 6'h00});
			text_valid <= 1'b1;
			video_valid <= 1'b1;
			repeat (45) @(posedge mclk);
			text_valid <= 1'b0;
			video_valid <= 1'b0;
			rd(ADDR_FILL, m == 0 ? 32'h0 : 32'h20);
			base = n_words;
			drain(40);
			chk("words", m == 0 ? 32'h0 : 32'h20, n_words - base);
		end
		// Empty read event: masked, then raised, then cleared by a read
		bus(ADDR_ARB, 1'b1, 32'h80);
		bus(ADDR_STATUS, 1'b0, 32'h0);
		drain(2);
		chk("irq", 32'h0, {31'h0, irq});
		bus(ADDR_MASK, 1'b1, 32'h4);
		repeat (2) @(posedge mclk);
		chk("irq", 32'h1, {31'h0, irq});
		rd(ADDR_STATUS, 32'h4);
		repeat (3) @(posedge mclk);
		chk("irq", 32'h0, {31'h0, irq});
		rd(ADDR_MASK, 32'h4);
		finish_test;
	end
endmodule
